// file: hw/hspwm_defs.svh
// Constants for the high-side PWM and bridge configuration register bank.
// Assumes a 10 MHz system clock and a serial frame decoder delivering 7-bit addresses.
`ifndef HSPWM_DEFS_SVH
`define HSPWM_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define HSPWM_ADDR_PWM_CFG 7'h0a
`define HSPWM_ADDR_SCRATCH 7'h0b
`define HSPWM_ADDR_BRIDGE 7'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HSPWM_PERIOD_BIT 14
`define HSPWM_DUTY_MSB 13
`define HSPWM_DUTY_LSB 4
`define HSPWM_SEL_MSB 2
`define HSPWM_PWM_CFG_MASK 16'h7ff7
`define HSPWM_PWM_CFG_RESTART_KEEP 16'h7ff0
`define HSPWM_BRIDGE_HI_MASK 16'hff00

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSPWM_PWM_CFG_RESET 16'h0000
`define HSPWM_SCRATCH_RESET 16'h0000
`define HSPWM_BRIDGE_RESET 16'h0801

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HSPWM_CLK_HZ 10000000
`define HSPWM_FREQ_SLOW_HZ 100
`define HSPWM_FREQ_FAST_HZ 200
`define HSPWM_DUTY_STEPS 1024
// Cycles per duty step at 200 Hz; 100 Hz uses every second enable.
`define HSPWM_STEP_CYCLES (`HSPWM_CLK_HZ / (`HSPWM_FREQ_FAST_HZ * `HSPWM_DUTY_STEPS))

`endif

// file: hw/hspwm_pkg.sv
// Types shared by the high-side PWM register bank.
// Assumes the constants header is included by the design files.
package hspwm_pkg;
	typedef logic [15:0] hspwm_word_t;
	typedef logic [9:0] hspwm_duty_t;
	typedef enum logic [1:0] {
		HSPWM_MODE_NORMAL = 2'b00,
		HSPWM_MODE_FAILSAFE = 2'b01,
		HSPWM_MODE_RESTART = 2'b10,
		HSPWM_MODE_OTHER = 2'b11
	} hspwm_mode_t;
	typedef enum logic [1:0] {
		HSPWM_GEN_IDLE = 2'b00,
		HSPWM_GEN_SETTLE = 2'b01,
		HSPWM_GEN_VALID = 2'b10
	} hspwm_gen_state_t;
endpackage

// file: hw/hspwm_gen.sv
// One internal high-side PWM generator.
// Assumes a shared one-cycle step enable and a synchronous active-low reset.
`timescale 1ns/1ns
module hspwm_gen (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Timing
	input wire logic step_en_in,
	// Configuration
	input wire logic period_select_in,
	input wire hspwm_pkg::hspwm_duty_t duty_in,
	input wire logic load_in,
	// Output
	output logic pwm_out,
	output logic valid_out
);
	import hspwm_pkg::*;

	logic [9:0] phase;
	logic half_tick;
	hspwm_gen_state_t state;
	logic step;

	// At 100 Hz each duty step takes two enables.
	assign step = step_en_in & (period_select_in | half_tick);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			half_tick <= 1'b0;
			phase <= 10'h000;
		end else if (load_in) begin
			half_tick <= 1'b0;
			phase <= 10'h000;
		end else if (step_en_in) begin
			half_tick <= ~half_tick;
			if (step) begin
				phase <= phase + 10'h001;
			end
		end
	end

	// Output counts as valid only after one full period from the last load.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			state <= HSPWM_GEN_IDLE;
		end else if (load_in) begin
			state <= HSPWM_GEN_SETTLE;
		end else begin
			case (state)
				HSPWM_GEN_IDLE: state <= HSPWM_GEN_IDLE;
				HSPWM_GEN_SETTLE: begin
					if (step && phase == 10'h3ff) begin
						state <= HSPWM_GEN_VALID;
					end
				end
				HSPWM_GEN_VALID: state <= HSPWM_GEN_VALID;
				default: state <= HSPWM_GEN_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pwm_out <= 1'b0;
			valid_out <= 1'b0;
		end else begin
			valid_out <= (state == HSPWM_GEN_VALID);
			if (duty_in == 10'h000) begin
				pwm_out <= 1'b0;
			end else if (duty_in == 10'h3ff) begin
				pwm_out <= 1'b1;
			end else begin
				pwm_out <= (phase < duty_in);
			end
		end
	end
endmodule

// file: hw/hspwm_regs.sv
// High-side PWM configuration, host scratch store and upper bridge control fields.
// Assumes a serial frame decoder that presents one 16-bit access per frame with a write strobe.
`timescale 1ns/1ns
`include "hspwm_defs.svh"
module hspwm_regs (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic soft_reset_in,
	input wire logic restart_reset_in,
	// Device mode
	input wire hspwm_pkg::hspwm_mode_t mode_in,
	// Serial frame access
	input wire logic frame_valid_in,
	input wire logic frame_write_in,
	input wire logic [6:0] frame_addr_in,
	input wire hspwm_pkg::hspwm_word_t frame_wdata_in,
	output hspwm_pkg::hspwm_word_t frame_rdata_out,
	output logic frame_hit_out,
	// External PWM inputs
	input wire logic [3:0] pwm_input_in,
	// High-side generator outputs
	output logic [3:0] highside_output_out,
	output logic [3:0] gen_valid_out,
	// Half-bridge control
	output logic [3:0] half_bridge_pwm_out,
	output logic driver_sync_rate_out,
	output logic pump_undervolt_level_out,
	output logic transistor_type_select_out,
	output logic pump_stage_auto_switch_out,
	output logic driver_overvolt_recovery_out,
	output logic gate_current_adapt_step_out
);
	import hspwm_pkg::*;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic addr_is(input logic [6:0] a, input logic [6:0] ref_addr);
		addr_is = (a == ref_addr);
	endfunction

	hspwm_word_t highside_pwm_config;
	hspwm_word_t host_scratch_store;
	hspwm_word_t bridge_general_config;
	logic [13:0] step_cnt;
	logic step_en;
	logic [3:0] gen_load;
	logic [3:0] gen_period;
	hspwm_duty_t gen_duty [0:3];
	logic [3:0] gen_pwm;
	logic scratch_ok;
	logic wr_pwm;
	logic wr_scratch;
	logic wr_bridge;
	logic next_hit;
	hspwm_word_t next_rdata;

	// ----------------------------------------------------------------
	// Write strobes
	// ----------------------------------------------------------------
	assign scratch_ok = (mode_in == HSPWM_MODE_NORMAL);
	assign wr_pwm = frame_valid_in & frame_write_in
		& addr_is(frame_addr_in, `HSPWM_ADDR_PWM_CFG);
	assign wr_scratch = frame_valid_in & frame_write_in & scratch_ok
		& addr_is(frame_addr_in, `HSPWM_ADDR_SCRATCH);
	assign wr_bridge = frame_valid_in & frame_write_in
		& addr_is(frame_addr_in, `HSPWM_ADDR_BRIDGE);

	// ----------------------------------------------------------------
	// PWM configuration register
	// ----------------------------------------------------------------
	// Duty and period survive a restart since their restart value is undefined.
	// A write that meets any reset in the same cycle is dropped from the register, but gen_load still fires on a restart.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || soft_reset_in) begin
			highside_pwm_config <= `HSPWM_PWM_CFG_RESET;
		end else if (restart_reset_in) begin
			highside_pwm_config <= highside_pwm_config & `HSPWM_PWM_CFG_RESTART_KEEP;
		end else if (wr_pwm) begin
			highside_pwm_config <= frame_wdata_in & `HSPWM_PWM_CFG_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Scratch register
	// ----------------------------------------------------------------
	// Restart and fail-safe do not touch it, so host data survives those modes.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || soft_reset_in) begin
			host_scratch_store <= `HSPWM_SCRATCH_RESET;
		end else if (wr_scratch) begin
			host_scratch_store <= frame_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Bridge general control register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || soft_reset_in) begin
			bridge_general_config <= `HSPWM_BRIDGE_RESET;
		end else if (wr_bridge) begin
			bridge_general_config <= frame_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		next_hit = 1'b1;
		next_rdata = 16'h0000;
		case (frame_addr_in)
			`HSPWM_ADDR_PWM_CFG: begin
				next_rdata = highside_pwm_config & `HSPWM_PWM_CFG_MASK;
			end
			`HSPWM_ADDR_SCRATCH: begin
				next_hit = scratch_ok;
				if (scratch_ok) begin
					next_rdata = host_scratch_store;
				end
			end
			`HSPWM_ADDR_BRIDGE: begin
				next_rdata = bridge_general_config;
			end
			default: begin
				next_hit = 1'b0;
			end
		endcase
	end

	// A write returns the value held before it, since the read is taken on the same edge.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			frame_rdata_out <= 16'h0000;
			frame_hit_out <= 1'b0;
		end else if (frame_valid_in) begin
			frame_rdata_out <= next_rdata;
			frame_hit_out <= next_hit;
		end
	end

	// ----------------------------------------------------------------
	// Step divider
	// ----------------------------------------------------------------
	// The divide truncates, so both rates run slightly fast but stay locked together.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			step_cnt <= 14'h0000;
			step_en <= 1'b0;
		end else if (step_cnt == 14'((`HSPWM_STEP_CYCLES) - 1)) begin
			step_cnt <= 14'h0000;
			step_en <= 1'b1;
		end else begin
			step_cnt <= step_cnt + 14'h0001;
			step_en <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Generators
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_slot
			// Only codes 0..3 load a generator; 1xx hits none.
			assign gen_load[g] = wr_pwm
				&& !frame_wdata_in[`HSPWM_SEL_MSB]
				&& frame_wdata_in[1:0] == 2'(g);

			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in || soft_reset_in) begin
					gen_period[g] <= 1'b0;
					gen_duty[g] <= 10'h000;
				end else if (gen_load[g]) begin
					gen_period[g] <= frame_wdata_in[`HSPWM_PERIOD_BIT];
					gen_duty[g] <= frame_wdata_in[`HSPWM_DUTY_MSB:`HSPWM_DUTY_LSB];
				end
			end

			hspwm_gen u_gen (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n_in),
				.step_en_in(step_en),
				.period_select_in(gen_period[g]),
				.duty_in(gen_duty[g]),
				.load_in(gen_load[g]),
				.pwm_out(gen_pwm[g]),
				.valid_out(gen_valid_out[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Generators feed only the high-side switches, never the bridge inputs.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			highside_output_out <= 4'h0;
		end else begin
			highside_output_out <= gen_pwm;
		end
	end

	// ----------------------------------------------------------------
	// Half-bridge routing
	// ----------------------------------------------------------------
	// A remapped pair parks its spare bridge low instead of leaving it floating.
	function automatic logic [1:0] pair_route(input logic swap, input logic [1:0] pins);
		if (swap) begin
			pair_route = {pins[0], 1'b0};
		end else begin
			pair_route = pins;
		end
	endfunction

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			half_bridge_pwm_out <= 4'h0;
		end else begin
			half_bridge_pwm_out[1:0] <= pair_route(bridge_general_config[13],
				pwm_input_in[1:0]);
			half_bridge_pwm_out[3:2] <= pair_route(bridge_general_config[14],
				pwm_input_in[3:2]);
		end
	end

	// ----------------------------------------------------------------
	// Bridge driver option fields
	// ----------------------------------------------------------------
	// Each option has its own flop and follows the register one clock later.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			driver_sync_rate_out <= 1'b0;
		end else begin
			driver_sync_rate_out <= bridge_general_config[15];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pump_undervolt_level_out <= 1'b0;
		end else begin
			pump_undervolt_level_out <= bridge_general_config[12];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			transistor_type_select_out <= 1'b1;
		end else begin
			transistor_type_select_out <= bridge_general_config[11];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pump_stage_auto_switch_out <= 1'b0;
		end else begin
			pump_stage_auto_switch_out <= bridge_general_config[10];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			driver_overvolt_recovery_out <= 1'b0;
		end else begin
			driver_overvolt_recovery_out <= bridge_general_config[9];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			gate_current_adapt_step_out <= 1'b0;
		end else begin
			gate_current_adapt_step_out <= bridge_general_config[8];
		end
	end
endmodule

// file: tb/hspwm_chk.sv
// Port checker for the configuration register bank.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/1ns
module hspwm_chk (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic soft_reset_in,
	input wire logic restart_reset_in,
	input wire hspwm_pkg::hspwm_mode_t mode_in,
	// Frame access
	input wire logic frame_valid_in,
	input wire logic frame_write_in,
	input wire logic [6:0] frame_addr_in,
	input wire hspwm_pkg::hspwm_word_t frame_wdata_in,
	input wire hspwm_pkg::hspwm_word_t frame_rdata_out,
	input wire logic frame_hit_out,
	// Bridge fields
	input wire logic driver_sync_rate_out,
	input wire logic pump_undervolt_level_out,
	input wire logic transistor_type_select_out,
	input wire logic pump_stage_auto_switch_out,
	input wire logic driver_overvolt_recovery_out,
	input wire logic gate_current_adapt_step_out
);
	import hspwm_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic rd, wr;
	logic [6:0] a;
	assign rd = frame_valid_in && !frame_write_in;
	assign wr = frame_valid_in && frame_write_in;
	assign a = frame_addr_in;
	res_bits_a: assert property (rd && a == 7'h0a |=> !frame_rdata_out[15] && !frame_rdata_out[3])
		else $error("reserved bits read nonzero");
	cfg_mask_a: assert property ((wr && a == 7'h0a && !soft_reset_in
		&& !restart_reset_in) ##1 (!frame_valid_in && !soft_reset_in && !restart_reset_in)
		##1 (rd && a == 7'h0a)
		|=> frame_hit_out && frame_rdata_out == ($past(frame_wdata_in, 3) & 16'h7ff7))
		else $error("config write not read back masked");
	scr_wr_a: assert property ((wr && a == 7'h0b && mode_in == HSPWM_MODE_NORMAL
		&& !soft_reset_in) ##1 (!frame_valid_in && !soft_reset_in)
		##1 (rd && a == 7'h0b && mode_in == HSPWM_MODE_NORMAL)
		|=> frame_hit_out && frame_rdata_out == $past(frame_wdata_in, 3))
		else $error("scratch write not read back");
	scr_deny_a: assert property (frame_valid_in && a == 7'h0b && mode_in != HSPWM_MODE_NORMAL
		|=> !frame_hit_out && frame_rdata_out == 16'h0000)
		else $error("scratch open outside normal mode");
	unmap_a: assert property (frame_valid_in && a != 7'h0a && a != 7'h0b && a != 7'h10
		|=> !frame_hit_out && frame_rdata_out == 16'h0000)
		else $error("unmapped address answered");
	bridge_out_a: assert property (wr && a == 7'h10
		&& !soft_reset_in |-> ##2
		{driver_sync_rate_out, pump_undervolt_level_out, transistor_type_select_out,
		pump_stage_auto_switch_out, driver_overvolt_recovery_out, gate_current_adapt_step_out}
		== {$past(frame_wdata_in[15], 2), $past(frame_wdata_in[12:8], 2)})
		else $error("bridge field outputs wrong");
	rst_def_a: assert property ($rose(rst_n_in) |-> !frame_hit_out && transistor_type_select_out)
		else $error("reset defaults wrong");
	soft_clr_a: assert property (soft_reset_in
		##1 (rd && a == 7'h0b && mode_in == HSPWM_MODE_NORMAL)
		|=> frame_rdata_out == 16'h0000)
		else $error("scratch kept over soft reset");
	cover property (wr && a == 7'h0a);
	cover property (frame_valid_in && a == 7'h0b && mode_in != HSPWM_MODE_NORMAL);
	cover property (wr && a == 7'h10);
endmodule

// file: tb/hspwm_host.sv
// Host model: one register access per call, answer taken one edge later.
// Assumes the bank samples a frame on the edge after valid is raised.
`timescale 1ns/1ns
module hspwm_host (
	// Clock
	input wire logic sys_clk_in,
	// Frame lines
	output logic valid_out,
	output logic write_out,
	output logic [6:0] addr_out,
	output hspwm_pkg::hspwm_word_t wdata_out,
	input wire hspwm_pkg::hspwm_word_t rdata_in,
	input wire logic hit_in
);
	import hspwm_pkg::*;
	initial valid_out = 1'b0;
	initial write_out = 1'b0;
	initial addr_out = 7'h7f;
	initial wdata_out = 16'h0000;
	// Idle address and data lines show the inverse so a stale frame is never reused by chance.
	task automatic acc(input logic w, input logic [6:0] a, input hspwm_word_t d,
		output hspwm_word_t rd, output logic h);
		@(posedge sys_clk_in);
		valid_out <= 1'b1;
		write_out <= w;
		addr_out <= a;
		wdata_out <= d;
		@(posedge sys_clk_in);
		valid_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
		#1;
		rd = rdata_in;
		h = hit_in;
	endtask
endmodule

// file: tb/tb_hs_pwm_and_bridge_config_regs.sv
// Bench for the configuration register bank, random and corner stimulus.
// Assumes the host model drives frames and the checker is bound below.
`timescale 1ns/1ns
module tb_hs_pwm_and_bridge_config_regs;
	import hspwm_pkg::*;
	logic sys_clk_in = 1'b0, rst_n_in = 1'b0, soft_reset_in = 1'b0, restart_reset_in = 1'b0;
	hspwm_mode_t mode_in = HSPWM_MODE_NORMAL;
	logic frame_valid_in, frame_write_in, frame_hit_out, hit;
	logic [6:0] frame_addr_in;
	hspwm_word_t frame_wdata_in, frame_rdata_out, rd, d;
	logic [3:0] pwm_input_in = 4'h0, highside_output_out, gen_valid_out, half_bridge_pwm_out;
	logic driver_sync_rate_out, pump_undervolt_level_out, transistor_type_select_out;
	logic pump_stage_auto_switch_out, driver_overvolt_recovery_out, gate_current_adapt_step_out;
	int seed, err_count, total_checks, i, c0, c1, c2, c3;
	always #50 sys_clk_in = ~sys_clk_in;
	hspwm_regs uut (.sys_clk_in, .rst_n_in, .soft_reset_in, .restart_reset_in, .mode_in,
		.frame_valid_in, .frame_write_in, .frame_addr_in, .frame_wdata_in, .frame_rdata_out,
		.frame_hit_out, .pwm_input_in, .highside_output_out, .gen_valid_out,
		.half_bridge_pwm_out, .driver_sync_rate_out, .pump_undervolt_level_out,
		.transistor_type_select_out, .pump_stage_auto_switch_out,
		.driver_overvolt_recovery_out, .gate_current_adapt_step_out);
	hspwm_host host (.sys_clk_in, .valid_out(frame_valid_in), .write_out(frame_write_in),
		.addr_out(frame_addr_in), .wdata_out(frame_wdata_in), .rdata_in(frame_rdata_out),
		.hit_in(frame_hit_out));
	// ----------------------------------------------------------------
	// Checks and expectations
	// ----------------------------------------------------------------
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input hspwm_word_t e, input logic eh);
		host.acc(1'b0, a, 16'h0000, rd, hit);
		chk({hit, rd}, {eh, e});
	endtask
	task automatic wr(input logic [6:0] a, input hspwm_word_t v);
		host.acc(1'b1, a, v, rd, hit);
	endtask
	// Unused half bridge after remapping reads low.
	function automatic logic [3:0] route(input hspwm_word_t br, input logic [3:0] p);
		route = p;
		if (br[13]) route[1:0] = {p[0], 1'b0};
		if (br[14]) route[3:2] = {p[2], 1'b0};
	endfunction
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		seed = 50506;
		repeat (20) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		rdc(7'h0a, 16'h0000, 1'b1);
		rdc(7'h0b, 16'h0000, 1'b1);
		rdc(7'h10, 16'h0801, 1'b1);
		rdc(7'h11, 16'h0000, 1'b0);
		for (i = 0; i < 24; i++) begin
			d = 16'($random(seed));
			mode_in <= hspwm_mode_t'(i[1:0]);
			wr(7'h0b, d);
			rdc(7'h0b, (i[1:0] == 2'b00) ? d : 16'h0000, i[1:0] == 2'b00);
			mode_in <= HSPWM_MODE_NORMAL;
			wr(7'h0a, d);
			rdc(7'h0a, d & 16'h7ff7, 1'b1);
			wr(7'h10, d);
			pwm_input_in <= 4'($random(seed));
			repeat (3) @(posedge sys_clk_in);
			chk(17'(half_bridge_pwm_out), 17'(route(d, pwm_input_in)));
		end
		wr(7'h0b, 16'ha5c3);
		wr(7'h0a, 16'hffff);
		mode_in <= HSPWM_MODE_FAILSAFE;
		@(posedge sys_clk_in) restart_reset_in <= 1'b1;
		@(posedge sys_clk_in) restart_reset_in <= 1'b0;
		mode_in <= HSPWM_MODE_NORMAL;
		rdc(7'h0a, 16'h7ff0, 1'b1);
		rdc(7'h0b, 16'ha5c3, 1'b1);
		@(posedge sys_clk_in) soft_reset_in <= 1'b1;
		fork
			host.acc(1'b0, 7'h0b, 16'h0000, rd, hit);
			@(posedge sys_clk_in) soft_reset_in <= 1'b0;
		join
		chk({hit, rd}, 17'h10000);
		rdc(7'h10, 16'h0801, 1'b1);
		// Duty is loaded before the outputs are looked at.
		wr(7'h0a, 16'h0000);
		wr(7'h0a, 16'h3ff1);
		wr(7'h0a, 16'h6002);
		wr(7'h0a, 16'h2003);
		chk(17'(gen_valid_out[2]), 17'h0);
		{c0, c1, c2, c3} = '0;
		repeat (49152) begin
			@(posedge sys_clk_in) pwm_input_in <= 4'($random(seed));
			#1;
			c0 += highside_output_out[0];
			c1 += highside_output_out[1];
			c2 += highside_output_out[2];
			c3 += highside_output_out[3];
		end
		chk(17'(c0), 17'h0);
		chk(17'(c1), 17'd49152);
		chk(17'(c2 > 24516 && c2 < 24636), 17'h1);
		chk(17'(c3 > 49092), 17'h1);
		repeat (60) @(posedge sys_clk_in);
		chk(17'(gen_valid_out[2]), 17'h1);
		stop_test();
	end
endmodule
bind hspwm_regs hspwm_chk chk (.sys_clk_in, .rst_n_in, .soft_reset_in, .restart_reset_in, .mode_in,
	.frame_valid_in, .frame_write_in, .frame_addr_in, .frame_wdata_in, .frame_rdata_out,
	.frame_hit_out, .driver_sync_rate_out, .pump_undervolt_level_out,
	.transistor_type_select_out, .pump_stage_auto_switch_out,
	.driver_overvolt_recovery_out, .gate_current_adapt_step_out);
